// ==== src/instr_decode_pkg.sv ====
package instr_decode_pkg;

  // ==========================================
  // Field positions
  localparam int DST_LO = 8;
  localparam int SRC_LO = 4;
  localparam int D4_LO  = 0;
  localparam int TOP_LO = 12;

  // ==========================================
  // Scaling shifts and fixed codes
  localparam logic [4:0]  SH_X1 = 5'h00;
  localparam logic [4:0]  SH_X2 = 5'h01;
  localparam logic [4:0]  SH_X4 = 5'h02;
  localparam logic [15:0] OP_TBIT_COPY = 16'h0029;

  typedef enum logic [3:0] {
    FMT_ZERO = 4'b0000, FMT_N   = 4'b0001, FMT_M   = 4'b0010,
    FMT_NM   = 4'b0011, FMT_MD  = 4'b0100, FMT_ND4 = 4'b0101,
    FMT_NMD  = 4'b0110, FMT_D   = 4'b0111, FMT_D12 = 4'b1000,
    FMT_ND8  = 4'b1001, FMT_I   = 4'b1010, FMT_NI  = 4'b1011
  } fmt_e;

  typedef enum logic [3:0] {
    M_NONE   = 4'b0000, M_REG     = 4'b0001, M_IND     = 4'b0010,
    M_POST   = 4'b0011, M_PRE     = 4'b0100, M_IDX_FIRST = 4'b0101,
    M_DISP   = 4'b0110, M_GBASE   = 4'b0111, M_GBASE_IDX = 4'b1000,
    M_PC_D   = 4'b1001, M_PC_REL  = 4'b1010, M_PC_REG  = 4'b1011,
    M_IMM    = 4'b1100, M_CTRL    = 4'b1101, M_MAC     = 4'b1110,
    M_FIRST  = 4'b1111
  } mode_e;

  typedef enum logic [1:0] {
    SZ_B = 2'b00, SZ_W = 2'b01, SZ_L = 2'b10, SZ_NONE = 2'b11
  } size_e;

  typedef struct packed {
    logic [15:0] opcode;
    fmt_e        fmt;
    mode_e       src_mode;
    mode_e       dst_mode;
    logic [3:0]  src_reg;
    logic [3:0]  dst_reg;
    logic        src2_valid;
    size_e       size;
    logic [31:0] disp;
    logic [31:0] imm;
    logic        pc_align;
    logic        illegal;
  } decode_s;

  localparam decode_s DECODE_RESET = '0;

endpackage

// ==== src/instr_format_field_decoder.sv ====
`timescale 1ns/1ps
module instr_format_field_decoder
  import instr_decode_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  output logic             valid_o,
  output decode_s          dec_o
);

  // ==========================================
  // Field extraction
  logic [3:0]  dest_register_field;
  logic [3:0]  source_register_field;
  logic [3:0]  top4;
  logic [3:0]  lo4;
  logic [3:0]  d4;
  logic [7:0]  d8;
  logic [11:0] d12;
  logic [31:0] zext8;
  logic [31:0] sext8;
  logic [31:0] zext4;
  logic [31:0] sext12;

  assign dest_register_field   = instr_i[DST_LO +: 4];
  assign source_register_field = instr_i[SRC_LO +: 4];
  assign top4   = instr_i[TOP_LO +: 4];
  assign lo4    = instr_i[3:0];
  assign d4     = instr_i[D4_LO +: 4];
  assign d8     = instr_i[7:0];
  assign d12    = instr_i[11:0];
  assign zext8  = {24'h000000, d8};
  assign sext8  = {{24{d8[7]}}, d8};
  assign zext4  = {28'h0000000, d4};
  assign sext12 = {{20{d12[11]}}, d12};

  // ==========================================
  // Format and operand decode
  decode_s dec;
  decode_s next_dec;
  logic    valid;
  logic    next_valid;

  always_comb begin
    next_dec        = DECODE_RESET;
    next_dec.opcode = instr_i;
    next_dec.size   = SZ_NONE;
    next_valid      = instr_valid_i;
    case (top4)
      4'h0: begin
        case (lo4)
          4'h4, 4'h5, 4'h6: begin
            next_dec.fmt      = FMT_NM;
            next_dec.src_mode = M_REG;
            next_dec.dst_mode = M_IDX_FIRST;
            next_dec.src_reg  = source_register_field;
            next_dec.dst_reg  = dest_register_field;
            next_dec.size     = size_e'(lo4[1:0]);
          end
          4'h7: begin
            next_dec.fmt      = FMT_NM;
            next_dec.src_mode = M_REG;
            next_dec.dst_mode = M_REG;
            next_dec.src_reg  = source_register_field;
            next_dec.dst_reg  = dest_register_field;
          end
          4'hC, 4'hD, 4'hE: begin
            next_dec.fmt      = FMT_NM;
            next_dec.src_mode = M_IDX_FIRST;
            next_dec.dst_mode = M_REG;
            next_dec.src_reg  = source_register_field;
            next_dec.dst_reg  = dest_register_field;
            next_dec.size     = size_e'(lo4[1:0]);
          end
          4'hF: begin
            next_dec.fmt        = FMT_NM;
            next_dec.src_mode   = M_POST;
            next_dec.dst_mode   = M_MAC;
            next_dec.src_reg    = source_register_field;
            next_dec.dst_reg    = dest_register_field;
            next_dec.src2_valid = 1'b1;
          end
          4'h2, 4'hA: begin
            next_dec.fmt      = FMT_N;
            next_dec.src_mode = M_CTRL;
            next_dec.dst_mode = M_REG;
            next_dec.dst_reg  = dest_register_field;
          end
          4'h3: begin
            next_dec.fmt      = FMT_M;
            next_dec.src_mode = M_PC_REG;
            next_dec.src_reg  = dest_register_field;
          end
          4'h9: begin
            if ({instr_i[15:12], 4'h0, instr_i[7:0]} == OP_TBIT_COPY) begin
              next_dec.fmt      = FMT_N;
              next_dec.dst_mode = M_REG;
              next_dec.dst_reg  = dest_register_field;
            end else begin
              next_dec.fmt = FMT_ZERO;
            end
          end
          4'h8, 4'hB: next_dec.fmt = FMT_ZERO;
          default: next_dec.illegal = 1'b1;
        endcase
      end
      4'h1, 4'h5: begin
        next_dec.fmt      = FMT_NMD;
        next_dec.src_mode = top4[2] ? M_DISP : M_REG;
        next_dec.dst_mode = top4[2] ? M_REG : M_DISP;
        next_dec.src_reg  = source_register_field;
        next_dec.dst_reg  = dest_register_field;
        next_dec.size     = SZ_L;
        next_dec.disp     = zext4 << SH_X4;
      end
      4'h2, 4'h6: begin
        next_dec.fmt     = FMT_NM;
        next_dec.src_reg = source_register_field;
        next_dec.dst_reg = dest_register_field;
        next_dec.src_mode = M_REG;
        next_dec.dst_mode = M_REG;
        if (lo4[3] == 1'b0 && lo4[1:0] != 2'b11) begin
          next_dec.size = size_e'(lo4[1:0]);
          if (top4[2]) begin
            next_dec.src_mode = lo4[2] ? M_POST : M_IND;
          end else begin
            next_dec.dst_mode = lo4[2] ? M_PRE : M_IND;
          end
        end
      end
      4'h3: begin
        next_dec.fmt      = FMT_NM;
        next_dec.src_mode = M_REG;
        next_dec.dst_mode = M_REG;
        next_dec.src_reg  = source_register_field;
        next_dec.dst_reg  = dest_register_field;
      end
      4'h4: begin
        case (lo4)
          4'hF: begin
            next_dec.fmt        = FMT_NM;
            next_dec.src_mode   = M_POST;
            next_dec.dst_mode   = M_MAC;
            next_dec.src_reg    = source_register_field;
            next_dec.dst_reg    = dest_register_field;
            next_dec.src2_valid = 1'b1;
            next_dec.size       = SZ_W;
          end
          4'hC, 4'hD: begin
            next_dec.fmt      = FMT_NM;
            next_dec.src_mode = M_REG;
            next_dec.dst_mode = M_REG;
            next_dec.src_reg  = source_register_field;
            next_dec.dst_reg  = dest_register_field;
          end
          4'h2, 4'h3: begin
            next_dec.fmt      = FMT_N;
            next_dec.src_mode = M_CTRL;
            next_dec.dst_mode = M_PRE;
            next_dec.dst_reg  = dest_register_field;
            next_dec.size     = SZ_L;
          end
          4'h6, 4'h7, 4'hA, 4'hE: begin
            next_dec.fmt      = FMT_M;
            next_dec.src_mode = lo4[3] ? M_REG : M_POST;
            next_dec.dst_mode = M_CTRL;
            next_dec.src_reg  = dest_register_field;
            next_dec.size     = lo4[3] ? SZ_NONE : SZ_L;
          end
          4'hB: begin
            if (source_register_field == 4'h1) begin
              next_dec.fmt      = FMT_N;
              next_dec.dst_mode = M_IND;
              next_dec.dst_reg  = dest_register_field;
              next_dec.size     = SZ_B;
            end else begin
              next_dec.fmt      = FMT_M;
              next_dec.src_mode = M_IND;
              next_dec.src_reg  = dest_register_field;
            end
          end
          default: begin
            next_dec.fmt      = FMT_N;
            next_dec.dst_mode = M_REG;
            next_dec.dst_reg  = dest_register_field;
          end
        endcase
      end
      4'h7, 4'hE: begin
        next_dec.fmt      = FMT_NI;
        next_dec.src_mode = M_IMM;
        next_dec.dst_mode = M_REG;
        next_dec.dst_reg  = dest_register_field;
        next_dec.imm      = sext8;
      end
      4'h8: begin
        case (dest_register_field)
          4'h0, 4'h1: begin
            next_dec.fmt      = FMT_ND4;
            next_dec.src_mode = M_FIRST;
            next_dec.dst_mode = M_DISP;
            next_dec.dst_reg  = source_register_field;
            next_dec.size     = size_e'(instr_i[9:8]);
            next_dec.disp     = zext4 << (instr_i[8] ? SH_X2 : SH_X1);
          end
          4'h4, 4'h5: begin
            next_dec.fmt      = FMT_MD;
            next_dec.src_mode = M_DISP;
            next_dec.dst_mode = M_FIRST;
            next_dec.src_reg  = source_register_field;
            next_dec.size     = size_e'(instr_i[9:8]);
            next_dec.disp     = zext4 << (instr_i[8] ? SH_X2 : SH_X1);
          end
          4'h8: begin
            next_dec.fmt      = FMT_I;
            next_dec.src_mode = M_IMM;
            next_dec.dst_mode = M_FIRST;
            next_dec.imm      = sext8;
          end
          4'h9, 4'hB, 4'hD, 4'hF: begin
            next_dec.fmt      = FMT_D;
            next_dec.src_mode = M_PC_REL;
            next_dec.disp     = sext8 << SH_X2;
          end
          default: next_dec.illegal = 1'b1;
        endcase
      end
      4'h9, 4'hD: begin
        next_dec.fmt      = FMT_ND8;
        next_dec.src_mode = M_PC_D;
        next_dec.dst_mode = M_REG;
        next_dec.dst_reg  = dest_register_field;
        next_dec.size     = top4[2] ? SZ_L : SZ_W;
        next_dec.disp     = zext8 << (top4[2] ? SH_X4 : SH_X2);
        next_dec.pc_align = top4[2];
      end
      4'hA, 4'hB: begin
        next_dec.fmt      = FMT_D12;
        next_dec.src_mode = M_PC_REL;
        next_dec.disp     = sext12 << SH_X2;
      end
      4'hC: begin
        case (dest_register_field)
          4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6: begin
            next_dec.fmt      = FMT_D;
            next_dec.src_mode = instr_i[10] ? M_GBASE : M_FIRST;
            next_dec.dst_mode = instr_i[10] ? M_FIRST : M_GBASE;
            next_dec.size     = size_e'(instr_i[9:8]);
            next_dec.disp     = zext8 << {3'b000, instr_i[9:8]};
          end
          4'h3: begin
            next_dec.fmt      = FMT_I;
            next_dec.src_mode = M_IMM;
            next_dec.imm      = zext8 << SH_X4;
          end
          4'h7: begin
            next_dec.fmt      = FMT_D;
            next_dec.src_mode = M_PC_D;
            next_dec.dst_mode = M_FIRST;
            next_dec.size     = SZ_L;
            next_dec.disp     = zext8 << SH_X4;
            next_dec.pc_align = 1'b1;
          end
          default: begin
            next_dec.fmt      = FMT_I;
            next_dec.src_mode = M_IMM;
            next_dec.dst_mode = instr_i[10] ? M_GBASE_IDX : M_FIRST;
            next_dec.size     = instr_i[10] ? SZ_B : SZ_NONE;
            next_dec.imm      = zext8;
          end
        endcase
      end
      default: next_dec.illegal = 1'b1;
    endcase
  end

  // Decoded word is held until the next valid word; consumers use valid_o
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dec   <= DECODE_RESET;
      valid <= 1'b0;
    end else begin
      dec   <= instr_valid_i ? next_dec : dec;
      valid <= next_valid;
    end
  end

  assign dec_o   = dec;
  assign valid_o = valid;

  // ==========================================
  // Checks
  logic [15:0] last_instr;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_instr <= 16'h0000;
    end else begin
      last_instr <= instr_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_top(logic [3:0] t);
    instr_valid_i && instr_i[15:12] == t;
  endsequence

  sequence s_low(logic [3:0] t, logic [3:0] l);
    s_top(t) ##0 instr_i[3:0] == l;
  endsequence

  AST_ZERO_FMT: assert property (instr_valid_i && instr_i == 16'h0009 |=>
    valid && dec.fmt == FMT_ZERO && dec.src_mode == M_NONE && dec.dst_mode == M_NONE)
    else $error("zero-operand word decoded with operands");
  AST_NM_FIELDS: assert property (s_top(4'h3) |=>
    dec.dst_reg == last_instr[11:8] && dec.src_reg == last_instr[7:4])
    else $error("two-register fields misplaced");
  AST_PRE_DEC: assert property (s_low(4'h2, 4'h6) |=>
    dec.dst_mode == M_PRE && dec.src_mode == M_REG && dec.size == SZ_L)
    else $error("pre-decrement store not decoded");
  AST_POST_INC: assert property (s_low(4'h6, 4'h5) |=>
    dec.src_mode == M_POST && dec.dst_mode == M_REG && dec.size == SZ_W)
    else $error("post-increment load not decoded");
  AST_MAC_SRC2: assert property (s_low(4'h4, 4'hF) |=>
    dec.src2_valid && dec.dst_mode == M_MAC && dec.src_mode == M_POST)
    else $error("multiply-accumulate operands wrong");
  AST_PC_LONG: assert property (s_top(4'hD) |=>
    dec.pc_align && dec.disp == {22'h0, last_instr[7:0], 2'b00})
    else $error("longword PC displacement wrong");
  AST_BRANCH12: assert property (s_top(4'hA) |=>
    dec.disp == {{19{last_instr[11]}}, last_instr[11:0], 1'b0})
    else $error("12-bit branch offset wrong");
  AST_IMM_SIGN: assert property (s_top(4'hE) |=>
    dec.imm == {{24{last_instr[7]}}, last_instr[7:0]} && dec.dst_reg == last_instr[11:8])
    else $error("move immediate not sign-extended");
  AST_TRAP: assert property (instr_valid_i && instr_i[15:8] == 8'hC3 |=>
    dec.imm == {22'h0, last_instr[7:0], 2'b00} && dec.fmt == FMT_I)
    else $error("trap offset wrong");
  AST_HOLD: assert property (!instr_valid_i |=> !valid && $stable(dec))
    else $error("decode changed without a new word");

endmodule // instr_format_field_decoder

// ==== testbench/fetch_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Instruction fetch stand-in
module fetch_model (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  output logic             instr_valid_o,
  output logic [15:0]      instr_o
);
  logic [15:0] q[$];
  logic        slow;
  int          wait_cnt;

  initial begin
    instr_valid_o = 1'b0;
    instr_o       = 16'hA5A5;
    slow          = 1'b0;
    wait_cnt      = 0;
  end

  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask

  // ==========================================
  // Delivery
  // Idle word flips each cycle so a stale word is never mistaken for a new one
  always @(negedge sys_clk_i) begin
    if (reset_n_i && q.size() > 0 && wait_cnt == 0) begin
      instr_valid_o <= 1'b1;
      instr_o       <= q.pop_front();
      wait_cnt      <= slow ? int'($urandom % 3) : 0;
    end else begin
      instr_valid_o <= 1'b0;
      instr_o       <= ~instr_o;
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule // fetch_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import instr_decode_pkg::*;
  typedef struct {
    logic [15:0] b;
    fmt_e        f;
    mode_e       s;
    mode_e       d;
    int          dk;
    int          ik;
  } case_s;

  logic        sys_clk;
  logic        reset_n;
  logic        instr_valid;
  logic [15:0] instr;
  logic        valid;
  decode_s     dec;
  logic        taken_v;
  logic [15:0] taken_w;
  logic [15:0] last_word;
  int          n_mismatch;
  int          checked;

  // ==========================================
  // Opcode table: base, format, modes, disp kind, imm kind
  case_s tbl[$] = '{
    '{16'h0009, FMT_ZERO, M_NONE, M_NONE, 0, 0}, '{16'h0029, FMT_N, M_NONE, M_REG, 0, 0},
    '{16'h4003, FMT_N, M_CTRL, M_PRE, 0, 0}, '{16'h400E, FMT_M, M_REG, M_CTRL, 0, 0},
    '{16'h4007, FMT_M, M_POST, M_CTRL, 0, 0}, '{16'h402B, FMT_M, M_IND, M_NONE, 0, 0},
    '{16'h0023, FMT_M, M_PC_REG, M_NONE, 0, 0}, '{16'h300C, FMT_NM, M_REG, M_REG, 0, 0},
    '{16'h2002, FMT_NM, M_REG, M_IND, 0, 0}, '{16'h400F, FMT_NM, M_POST, M_MAC, 0, 0},
    '{16'h6005, FMT_NM, M_POST, M_REG, 0, 0}, '{16'h2006, FMT_NM, M_REG, M_PRE, 0, 0},
    '{16'h0006, FMT_NM, M_REG, M_IDX_FIRST, 0, 0}, '{16'h8400, FMT_MD, M_DISP, M_FIRST, 1, 0},
    '{16'h8000, FMT_ND4, M_FIRST, M_DISP, 1, 0}, '{16'h1000, FMT_NMD, M_REG, M_DISP, 2, 0},
    '{16'h5000, FMT_NMD, M_DISP, M_REG, 2, 0}, '{16'hC600, FMT_D, M_GBASE, M_FIRST, 3, 0},
    '{16'hC200, FMT_D, M_FIRST, M_GBASE, 3, 0}, '{16'hC100, FMT_D, M_FIRST, M_GBASE, 4, 0},
    '{16'hC000, FMT_D, M_FIRST, M_GBASE, 7, 0}, '{16'hC700, FMT_D, M_PC_D, M_FIRST, 3, 0},
    '{16'h8B00, FMT_D, M_PC_REL, M_NONE, 5, 0}, '{16'hA000, FMT_D12, M_PC_REL, M_NONE, 6, 0},
    '{16'hD000, FMT_ND8, M_PC_D, M_REG, 3, 0}, '{16'h9000, FMT_ND8, M_PC_D, M_REG, 4, 0},
    '{16'hCD00, FMT_I, M_IMM, M_GBASE_IDX, 0, 1}, '{16'hC900, FMT_I, M_IMM, M_FIRST, 0, 1},
    '{16'hC800, FMT_I, M_IMM, M_FIRST, 0, 1}, '{16'hCA00, FMT_I, M_IMM, M_FIRST, 0, 1},
    '{16'hCB00, FMT_I, M_IMM, M_FIRST, 0, 1}, '{16'h8800, FMT_I, M_IMM, M_FIRST, 0, 2},
    '{16'hC300, FMT_I, M_IMM, M_NONE, 0, 3}, '{16'h7000, FMT_NI, M_IMM, M_REG, 0, 2},
    '{16'hE000, FMT_NI, M_IMM, M_REG, 0, 2}, '{16'h000C, FMT_NM, M_IDX_FIRST, M_REG, 0, 0},
    '{16'h0007, FMT_NM, M_REG, M_REG, 0, 0}, '{16'h000F, FMT_NM, M_POST, M_MAC, 0, 0},
    '{16'h000A, FMT_N, M_CTRL, M_REG, 0, 0}, '{16'h0008, FMT_ZERO, M_NONE, M_NONE, 0, 0},
    '{16'h401B, FMT_N, M_NONE, M_IND, 0, 0}, '{16'h4010, FMT_N, M_NONE, M_REG, 0, 0},
    '{16'h200B, FMT_NM, M_REG, M_REG, 0, 0}, '{16'h8500, FMT_MD, M_DISP, M_FIRST, 1, 0},
    '{16'h8100, FMT_ND4, M_FIRST, M_DISP, 1, 0}, '{16'h8900, FMT_D, M_PC_REL, M_NONE, 5, 0},
    '{16'hB000, FMT_D12, M_PC_REL, M_NONE, 6, 0}, '{16'hC400, FMT_D, M_GBASE, M_FIRST, 7, 0},
    '{16'hC500, FMT_D, M_GBASE, M_FIRST, 4, 0}, '{16'hF000, FMT_D12, M_NONE, M_NONE, 0, 0}};

  instr_format_field_decoder dut_u (
    .sys_clk_i    (sys_clk),
    .reset_n_i    (reset_n),
    .instr_valid_i(instr_valid),
    .instr_i      (instr),
    .valid_o      (valid),
    .dec_o        (dec)
  );

  fetch_model fetch_u (
    .sys_clk_i    (sys_clk),
    .reset_n_i    (reset_n),
    .instr_valid_o(instr_valid),
    .instr_o      (instr)
  );

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // ==========================================
  // Reference model
  function automatic logic [15:0] fill(fmt_e f);
    case (f)
      FMT_ZERO: return 16'h0000;
      FMT_N, FMT_M: return 16'h0F00;
      FMT_NM: return 16'h0FF0;
      FMT_NMD, FMT_D12, FMT_ND8, FMT_NI: return 16'h0FFF;
      default: return 16'h00FF;
    endcase
  endfunction

  function automatic int exp_disp(int dk, logic [15:0] w);
    case (dk)
      1: return (w[8] ? 2 : 1) * int'(w[3:0]);
      2: return 4 * int'(w[3:0]);
      3: return 4 * int'(w[7:0]);
      4: return 2 * int'(w[7:0]);
      5: return 2 * int'($signed(w[7:0]));
      6: return 2 * int'($signed(w[11:0]));
      default: return int'(w[7:0]);
    endcase
  endfunction

  // Operand size follows the scale that the displacement kind implies, except branch kinds 5 and 6, which give none
  function automatic size_e exp_size(int dk, logic [15:0] w);
    case (dk)
      1: return w[8] ? SZ_W : SZ_B;
      2, 3: return SZ_L;
      4: return SZ_W;
      7: return SZ_B;
      default: return SZ_NONE;
    endcase
  endfunction

  task automatic chk_word(input logic [15:0] w);
    case_s e;
    int    imm;
    e = tbl[0];
    foreach (tbl[i]) begin
      if ((w & ~fill(tbl[i].f)) == tbl[i].b) begin
        e = tbl[i];
        break;
      end
    end
    if (e.b[15:12] == 4'hF) begin
      `CHK("illegal", 1'b1, dec.illegal)
      return;
    end
    imm = (e.ik == 2) ? int'($signed(w[7:0])) : int'(w[7:0]) * ((e.ik == 3) ? 4 : 1);
    `CHK("opcode", w, dec.opcode)
    `CHK("illegal", 1'b0, dec.illegal)
    `CHK("fmt", e.f, dec.fmt)
    if (e.s != M_NONE) `CHK("src_mode", e.s, dec.src_mode)
    if (e.d != M_NONE) `CHK("dst_mode", e.d, dec.dst_mode)
    if (e.f inside {FMT_M, FMT_NM, FMT_NMD, FMT_MD})
      `CHK("src_reg", (e.f == FMT_M) ? w[11:8] : w[7:4], dec.src_reg)
    if (e.f inside {FMT_N, FMT_NM, FMT_NMD, FMT_ND8, FMT_NI, FMT_ND4})
      `CHK("dst_reg", (e.f == FMT_ND4) ? w[7:4] : w[11:8], dec.dst_reg)
    `CHK("src2", e.d == M_MAC, dec.src2_valid)
    if (e.dk != 0) `CHK("disp", 32'(exp_disp(e.dk, w)), dec.disp)
    if (e.dk != 0) `CHK("pc_align", e.s == M_PC_D && e.dk == 3, dec.pc_align)
    if (e.dk != 0) `CHK("size", exp_size(e.dk, w), dec.size)
    if (e.ik != 0) `CHK("imm", 32'(imm), dec.imm)
  endtask

  // ==========================================
  // Monitor: capture on rising edge, compare once settled
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      taken_v <= 1'b0;
    end else begin
      taken_v <= instr_valid;
      taken_w <= instr;
    end
  end

  always @(negedge sys_clk) begin
    if (!reset_n) begin
      `CHK("valid_rst", 1'b0, valid)
      `CHK("dec_rst", DECODE_RESET, dec)
      last_word = 16'h0000;
    end else if (taken_v) begin
      `CHK("valid", 1'b1, valid)
      chk_word(taken_w);
      last_word = taken_w;
    end else begin
      `CHK("valid_idle", 1'b0, valid)
      `CHK("hold", last_word, dec.opcode)
    end
  end

  // ==========================================
  // Stimulus
  task automatic run(input int n);
    case_s e;
    for (int i = 0; i < n; i++) begin
      e = tbl[$urandom % tbl.size()];
      fetch_u.push(e.b | (16'($urandom) & fill(e.f)));
    end
    for (int k = 0; k < n * 4 + 20 && fetch_u.q.size() > 0; k++) begin
      @(negedge sys_clk);
    end
    repeat (3) @(negedge sys_clk);
    `CHK("queue_left", 0, fetch_u.q.size())
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    checked    = 0;
    reset_n    = 1'b0;
    void'($urandom(11949));
    repeat (5) @(negedge sys_clk);
    reset_n <= 1'b1;
    run(300);
    fetch_u.slow = 1'b1;
    run(300);
    // Reset lands with words still queued and one in flight
    run(0);
    for (int i = 0; i < 20; i++) begin
      fetch_u.push(16'h6005 | (16'($urandom) & 16'h0FF0));
    end
    repeat (5) @(negedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(negedge sys_clk);
    reset_n <= 1'b1;
    fetch_u.slow = 1'b0;
    run(50);
    results();
  end

  // Far above the expected run of some 1000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule // tb
